/* File: design/eeprom_wp_pkg.sv */
// Constants for the protected two-wire EEPROM slave
`default_nettype none
package eeprom_wp_pkg;
	localparam int          PAGE_COUNT      = 16;
	localparam int          PAGE_BYTES      = 16;
	localparam int          ARRAY_BYTES     = PAGE_COUNT * PAGE_BYTES;
	localparam int          WORD_ADDR_BITS  = 8;
	localparam logic [3:0]  PREAMBLE_ARRAY  = 4'hA;
	localparam logic [3:0]  PREAMBLE_FLAGS  = 4'h6;
	localparam logic [7:0]  LOWER_HALF_LAST = 8'h7F;
	localparam logic [7:0]  ERASED_BYTE     = 8'hFF;
	localparam logic        FLAG_RESET      = 1'b0;
	localparam logic [2:0]  SCL_GLITCH_LEN  = 3'h2;
	// Bus states, Gray coded along the usual path
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_DEV   = 3'b001,
		ST_DACK  = 3'b011,
		ST_WADR  = 3'b010,
		ST_WACK  = 3'b110,
		ST_DATA  = 3'b111,
		ST_DTACK = 3'b101,
		ST_RD    = 3'b100
	} bus_state_t;
endpackage : eeprom_wp_pkg
`default_nettype wire

/* File: design/eeprom_wp_slave.sv */
// Two-wire EEPROM slave with address match and write protection
//
// Operation
// - Array is sixteen pages of sixteen bytes, 256 locations.
// - One eight-bit word address selects any byte.
// - Sample SDA on SCL rise, change SDA after SCL fall.
// - SDA only pulled low or released, never driven high.
// - Three address-select pins form part of the bus identity.
// - Respond only when sent address bits match the select pins.
// - Floating address-select pins read as low.
// - Write-protect low: writes proceed, subject to software flags.
// - Write-protect high: whole array is write protected.
// - Floating write-protect pin reads as low.
// - Either flag set protects 00h to 7Fh; none, nothing protected.
// - Preamble 1010 for array, 0110 for protect flag commands.
// - Protected writes are acknowledged but data stays unchanged.
// - Flags cannot be programmed while write-protect is high.
`timescale 1ns/1ns
`default_nettype none
module eeprom_wp_slave #(
	parameter int ADDR_W = eeprom_wp_pkg::WORD_ADDR_BITS
) (
	input  wire logic       clk_sys,
	input  wire logic       rstn,
	input  wire logic       sclIn,
	input  wire logic       sdaIn,
	output logic            sdaOut,
	output logic            sdaOe,
	input  wire logic [2:0] addressSelectPins,
	input  wire logic       writeProtect,
	output logic            permanentProtectFlag,
	output logic            reversibleProtectFlag,
	output logic            busBusy
);
	//****************************************
	// Input synchronisers
	//****************************************
	// Pins pass two flops; pull-downs make a float arrive as zero
	logic [1:0] sclSync_reg, sdaSync_reg, wpSync_reg;
	logic [1:0] sclSync_next, sdaSync_next, wpSync_next;
	logic [2:0] aselMeta_reg, aselSync_reg;
	logic [2:0] aselMeta_next, aselSync_next;
	logic       sclPrev_reg, sdaPrev_reg;
	logic       sclPrev_next, sdaPrev_next;

	always_comb begin
		sclSync_next  = {sclSync_reg[0], sclIn};
		sdaSync_next  = {sdaSync_reg[0], sdaIn};
		wpSync_next   = {wpSync_reg[0], writeProtect};
		aselMeta_next = addressSelectPins;
		aselSync_next = aselMeta_reg;
		sclPrev_next  = sclSync_reg[1];
		sdaPrev_next  = sdaSync_reg[1];
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			sclSync_reg  <= 2'h3;
			sdaSync_reg  <= 2'h3;
			wpSync_reg   <= 2'h0;
			aselMeta_reg <= 3'h0;
			aselSync_reg <= 3'h0;
			sclPrev_reg  <= 1'h1;
			sdaPrev_reg  <= 1'h1;
		end else begin
			sclSync_reg  <= sclSync_next;
			sdaSync_reg  <= sdaSync_next;
			wpSync_reg   <= wpSync_next;
			aselMeta_reg <= aselMeta_next;
			aselSync_reg <= aselSync_next;
			sclPrev_reg  <= sclPrev_next;
			sdaPrev_reg  <= sdaPrev_next;
		end
	end

	logic scl, sda, wpHigh, sclRise, sclFall, startSeen, stopSeen;
	logic [2:0] aselLevel;
	always_comb begin
		scl       = sclSync_reg[1];
		sda       = sdaSync_reg[1];
		wpHigh    = wpSync_reg[1];
		aselLevel = aselSync_reg;
		sclRise   = scl && !sclPrev_reg;
		sclFall   = !scl && sclPrev_reg;
		startSeen = scl && sclPrev_reg && sdaPrev_reg && !sda;
		stopSeen  = scl && sclPrev_reg && !sdaPrev_reg && sda;
	end

	//****************************************
	// Protection decision
	//****************************************
	function automatic logic isProtected(input logic [7:0] addr, input logic wp,
			input logic perm, input logic rev);
		if (wp)
			isProtected = 1'b1;
		else if (perm || rev)
			isProtected = (addr <= eeprom_wp_pkg::LOWER_HALF_LAST);
		else
			isProtected = 1'b0;
	endfunction : isProtected

	//****************************************
	// Array
	//****************************************
	// sixteen by sixteen
	logic [7:0] memArray [eeprom_wp_pkg::ARRAY_BYTES];

	//****************************************
	// Bus engine
	//****************************************
	eeprom_wp_pkg::bus_state_t state_reg, state_next;
	logic [7:0]        shift_reg, shift_next;
	logic [3:0]        bitCnt_reg, bitCnt_next;
	logic [ADDR_W-1:0] wordAddr_reg, wordAddr_next;
	logic              flagCmd_reg, flagCmd_next;
	logic              readMode_reg, readMode_next;
	logic              busy_reg, busy_next;
	logic              sdaOe_reg, sdaOe_next;
	logic              permFlag_reg, permFlag_next;
	logic              revFlag_reg, revFlag_next;
	logic              memWrite;
	logic [7:0]        memWrAddr, memWrData;
	logic              devMatch, wordDone;

	always_comb begin
		state_next    = state_reg;
		shift_next    = shift_reg;
		bitCnt_next   = bitCnt_reg;
		wordAddr_next = wordAddr_reg;
		flagCmd_next  = flagCmd_reg;
		readMode_next = readMode_reg;
		sdaOe_next    = sdaOe_reg;
		permFlag_next = permFlag_reg;
		revFlag_next  = revFlag_reg;
		memWrite      = 1'b0;
		memWrAddr     = wordAddr_reg;
		memWrData     = shift_reg;
		wordDone      = (bitCnt_reg == 4'h8);
		devMatch      = (shift_reg[7:4] == eeprom_wp_pkg::PREAMBLE_ARRAY ||
				(shift_reg[7:4] == eeprom_wp_pkg::PREAMBLE_FLAGS && !permFlag_reg)) &&
				(shift_reg[3:1] == aselLevel);
		if (startSeen) begin
			state_next  = eeprom_wp_pkg::ST_DEV;
			bitCnt_next = 4'h0;
			sdaOe_next  = 1'b0;
		end else if (stopSeen) begin
			state_next = eeprom_wp_pkg::ST_IDLE;
			sdaOe_next = 1'b0;
		end else if (sclRise && state_reg != eeprom_wp_pkg::ST_IDLE &&
				state_reg != eeprom_wp_pkg::ST_DACK && state_reg != eeprom_wp_pkg::ST_WACK &&
				state_reg != eeprom_wp_pkg::ST_DTACK && state_reg != eeprom_wp_pkg::ST_RD) begin
			shift_next  = {shift_reg[6:0], sda};
			bitCnt_next = bitCnt_reg + 4'h1;
		end else if (sclFall) begin
			case (state_reg)
				eeprom_wp_pkg::ST_DEV: begin
					if (wordDone) begin
						if (devMatch) begin
							flagCmd_next  = (shift_reg[7:4] == eeprom_wp_pkg::PREAMBLE_FLAGS);
							readMode_next = shift_reg[0];
							sdaOe_next    = 1'b1;
							state_next    = eeprom_wp_pkg::ST_DACK;
						end else begin
							state_next = eeprom_wp_pkg::ST_IDLE;
						end
					end
				end
				eeprom_wp_pkg::ST_DACK: begin
					bitCnt_next = 4'h0;
					if (readMode_reg) begin
						shift_next = memArray[wordAddr_reg];
						sdaOe_next = !memArray[wordAddr_reg][7];
						state_next = eeprom_wp_pkg::ST_RD;
					end else begin
						sdaOe_next = 1'b0;
						state_next = eeprom_wp_pkg::ST_WADR;
					end
				end
				eeprom_wp_pkg::ST_WADR: begin
					if (wordDone) begin
						wordAddr_next = shift_reg[ADDR_W-1:0];
						sdaOe_next    = 1'b1;
						state_next    = eeprom_wp_pkg::ST_WACK;
					end
				end
				eeprom_wp_pkg::ST_WACK, eeprom_wp_pkg::ST_DTACK: begin
					sdaOe_next  = 1'b0;
					bitCnt_next = 4'h0;
					state_next  = eeprom_wp_pkg::ST_DATA;
				end
				eeprom_wp_pkg::ST_DATA: begin
					if (wordDone) begin
						sdaOe_next = 1'b1;
						state_next = eeprom_wp_pkg::ST_DTACK;
						if (flagCmd_reg) begin
							if (!wpHigh) begin
								if (shift_reg[0] && !shift_reg[1] && aselLevel == 3'h1)
									revFlag_next = 1'b1;
								else if (shift_reg[1] && aselLevel == 3'h3)
									revFlag_next = 1'b0;
								else
									permFlag_next = 1'b1;
							end
						end else if (!isProtected(wordAddr_reg, wpHigh, permFlag_reg, revFlag_reg)) begin
							memWrite = 1'b1;
						end
						if (!flagCmd_reg)
							wordAddr_next = {wordAddr_reg[7:4], wordAddr_reg[3:0] + 4'h1};
					end
				end
				eeprom_wp_pkg::ST_RD: begin
					if (bitCnt_reg == 4'h7) begin
						// Master acknowledge slot: release and take next byte
						sdaOe_next    = 1'b0;
						bitCnt_next   = 4'h8;
						wordAddr_next = wordAddr_reg + 8'h01;
					end else if (bitCnt_reg == 4'h8) begin
						// No master ack ends the read and returns to idle at that SCL fall, before any stop
						if (sda) begin
							state_next = eeprom_wp_pkg::ST_IDLE;
						end else begin
							bitCnt_next = 4'h0;
							shift_next  = memArray[wordAddr_reg];
							sdaOe_next  = !memArray[wordAddr_reg][7];
						end
					end else begin
						bitCnt_next = bitCnt_reg + 4'h1;
						shift_next  = {shift_reg[6:0], 1'b0};
						sdaOe_next  = !shift_reg[6];
					end
				end
				default: begin
					sdaOe_next = 1'b0;
				end
			endcase
		end
		busy_next     = (state_next != eeprom_wp_pkg::ST_IDLE);
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			state_reg    <= eeprom_wp_pkg::ST_IDLE;
			shift_reg    <= 8'h00;
			bitCnt_reg   <= 4'h0;
			wordAddr_reg <= '0;
			flagCmd_reg  <= 1'b0;
			readMode_reg <= 1'b0;
			busy_reg     <= 1'b0;
			sdaOe_reg    <= 1'b0;
			permFlag_reg <= eeprom_wp_pkg::FLAG_RESET;
			revFlag_reg  <= eeprom_wp_pkg::FLAG_RESET;
		end else begin
			state_reg    <= state_next;
			shift_reg    <= shift_next;
			bitCnt_reg   <= bitCnt_next;
			wordAddr_reg <= wordAddr_next;
			flagCmd_reg  <= flagCmd_next;
			readMode_reg <= readMode_next;
			busy_reg     <= busy_next;
			sdaOe_reg    <= sdaOe_next;
			permFlag_reg <= permFlag_next;
			revFlag_reg  <= revFlag_next;
		end
	end

	// Array holds no reset: contents model nonvolatile storage
	always_ff @(posedge clk_sys) begin
		if (rstn && memWrite)
			memArray[memWrAddr] <= memWrData;
	end

	//****************************************
	// Outputs
	//****************************************
	// open drain low only
	always_comb begin
		sdaOut                = 1'b0;
		sdaOe                 = sdaOe_reg;
		permanentProtectFlag  = permFlag_reg;
		reversibleProtectFlag = revFlag_reg;
		busBusy               = busy_reg;
	end
endmodule : eeprom_wp_slave
`default_nettype wire

/* File: verif/eeprom_wp_slave_asserts.sv */
// Port checker for the protected EEPROM slave
`timescale 1ns/1ns
`default_nettype none
module eeprom_wp_slave_asserts (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic sclIn,
	input wire logic sdaOut,
	input wire logic sdaOe,
	input wire logic writeProtect,
	input wire logic permanentProtectFlag,
	input wire logic reversibleProtectFlag,
	input wire logic busBusy
);
	// ****
	// Properties
	// ****
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	AST_SDA_NEVER_HIGH: assert property (sdaOut == 1'b0)
		else $error("sda data value not low");
	AST_RESET_STATE: assert property ($rose(rstn) |-> !sdaOe && !busBusy
		&& !permanentProtectFlag && !reversibleProtectFlag) else $error("bad state after reset");
	AST_SDA_MOVES_SCL_LOW: assert property ($changed(sdaOe) |-> !sclIn)
		else $error("sda moved while scl high");
	AST_SDA_HOLDS_SCL_HIGH: assert property (sclIn [*5] |-> $stable(sdaOe))
		else $error("sda unstable in scl high");
	AST_DRIVE_ONLY_BUSY: assert property (sdaOe |-> busBusy)
		else $error("sda pulled while idle");
	AST_WP_FREEZES_FLAGS: assert property (writeProtect [*6] |=>
		$stable(permanentProtectFlag) && $stable(reversibleProtectFlag)) else $error("flag moved under wp");
	AST_PERMANENT_STICKS: assert property (permanentProtectFlag |=> permanentProtectFlag)
		else $error("permanent flag cleared");
	AST_SDA_RELEASED_SOON: assert property ($rose(sdaOe) |-> ##[1:400] !sdaOe)
		else $error("sda held too long");
endmodule : eeprom_wp_slave_asserts
bind eeprom_wp_slave eeprom_wp_slave_asserts chkU (.clk_sys(clk_sys), .rstn(rstn), .sclIn(sclIn),
	.sdaOut(sdaOut), .sdaOe(sdaOe), .writeProtect(writeProtect), .busBusy(busBusy),
	.permanentProtectFlag(permanentProtectFlag), .reversibleProtectFlag(reversibleProtectFlag));
`default_nettype wire

/* File: verif/eeprom_write_protect_addressing_tb.sv */
// Self-checking bench for the protected EEPROM slave
`timescale 1ns/1ns
`default_nettype none
module eeprom_write_protect_addressing_tb;
	logic       clk_sys = 1'b0;
	logic       rstn = 1'b0;
	logic [2:0] sel = 3'h5;
	logic       wp = 1'b0;
	logic       scl;
	logic       mOe;
	logic       sdaOe;
	logic       sdaOut;
	logic       perm;
	logic       rev;
	logic       busy;
	wire        sda;
	int         bad_count = 0;
	int         checked = 0;
	// ****
	// Harness
	// ****
	// Pull-up unless a party pulls low
	assign sda = !(sdaOe | mOe);
	eeprom_wp_slave dut_u (.clk_sys(clk_sys), .rstn(rstn), .sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut),
		.sdaOe(sdaOe), .addressSelectPins(sel), .writeProtect(wp), .permanentProtectFlag(perm),
		.reversibleProtectFlag(rev), .busBusy(busy));
	two_wire_master masterU (.clk_sys(clk_sys), .sdaWire(sda), .sclLine(scl), .masterOe(mOe));
	initial begin
		forever #2 clk_sys = !clk_sys;
	end
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp
	task automatic wr(input logic [3:0] p, input logic [2:0] s, input logic [7:0] ad, input logic [7:0] d,
		output logic [2:0] a);
		logic [7:0] q;
		masterU.startCond();
		masterU.xfer({p, s, 1'b0}, 1'b1, q, a[2]);
		masterU.xfer(ad, 1'b1, q, a[1]);
		masterU.xfer(d, 1'b1, q, a[0]);
		masterU.stopCond();
	endtask : wr
	task automatic rd(input logic [2:0] s, input logic [7:0] ad, output logic [7:0] q);
		logic a;
		masterU.startCond();
		masterU.xfer({4'hA, s, 1'b0}, 1'b1, q, a);
		masterU.xfer(ad, 1'b1, q, a);
		masterU.startCond();
		masterU.xfer({4'hA, s, 1'b1}, 1'b1, q, a);
		masterU.xfer(8'hFF, 1'b1, q, a);
		masterU.stopCond();
	endtask : rd
	task automatic scnPlain();
		logic [2:0] a;
		logic [7:0] q;
		wr(4'hA, 3'h5, 8'h85, 8'h5A, a);
		cmp({5'h0, a}, 8'h07);
		rd(3'h5, 8'h85, q);
		cmp(q, 8'h5A);
		wr(4'hA, 3'h5, 8'hFF, 8'hC3, a);
		rd(3'h5, 8'hFF, q);
		cmp(q, 8'hC3);
		wr(4'hA, 3'h5, 8'h10, 8'h3C, a);
	endtask : scnPlain
	task automatic scnSelect();
		logic [2:0] a;
		logic [7:0] q;
		for (int i = 0; i < 8; i++) begin
			wr(4'hA, 3'(i), 8'h40, 8'(i), a);
			cmp({7'h0, a[2]}, {7'h0, i == 5});
		end
		rd(3'h5, 8'h40, q);
		cmp(q, 8'h05);
		wr(4'hB, 3'h5, 8'h40, 8'h99, a);
		cmp({7'h0, a[2]}, 8'h00);
	endtask : scnSelect
	task automatic scnHard();
		logic [2:0] a;
		logic [7:0] q;
		wp <= 1'b1;
		wr(4'hA, 3'h5, 8'h85, 8'h11, a);
		cmp({5'h0, a}, 8'h07);
		rd(3'h5, 8'h85, q);
		cmp(q, 8'h5A);
		wr(4'h6, 3'h5, 8'h00, 8'h00, a);
		cmp({6'h0, perm, rev}, 8'h00);
		wp <= 1'b0;
	endtask : scnHard
	task automatic scnSoft();
		logic [2:0] a;
		logic [7:0] q;
		sel <= 3'h1;
		wr(4'h6, 3'h1, 8'h00, 8'h01, a);
		cmp({6'h0, perm, rev}, 8'h01);
		wr(4'hA, 3'h1, 8'h10, 8'h77, a);
		rd(3'h1, 8'h10, q);
		cmp(q, 8'h3C);
		wr(4'hA, 3'h1, 8'h80, 8'h66, a);
		rd(3'h1, 8'h80, q);
		cmp(q, 8'h66);
		sel <= 3'h3;
		wr(4'h6, 3'h3, 8'h00, 8'h02, a);
		wr(4'hA, 3'h3, 8'h10, 8'h77, a);
		rd(3'h3, 8'h10, q);
		cmp({q[6:0], rev}, 8'hEE);
	endtask : scnSoft
	task automatic scnPerm();
		logic [2:0] a;
		logic [7:0] q;
		sel <= 3'h0;
		wr(4'h6, 3'h0, 8'h00, 8'h00, a);
		cmp({6'h0, perm, rev}, 8'h02);
		wr(4'hA, 3'h0, 8'h10, 8'h3C, a);
		rd(3'h0, 8'h10, q);
		cmp(q, 8'h77);
		wr(4'h6, 3'h0, 8'h00, 8'h00, a);
		cmp({7'h0, a[2]}, 8'h00);
	endtask : scnPerm
	// Page write rolls 9Fh over to 90h; sequential read walks on
	task automatic scnPage();
		logic [7:0] q;
		logic       a;
		masterU.startCond();
		masterU.xfer(8'hA0, 1'b1, q, a);
		masterU.xfer(8'h9F, 1'b1, q, a);
		masterU.xfer(8'h11, 1'b1, q, a);
		masterU.xfer(8'h22, 1'b1, q, a);
		masterU.xfer(8'h33, 1'b1, q, a);
		masterU.stopCond();
		rd(3'h0, 8'h9F, q);
		cmp(q, 8'h11);
		masterU.startCond();
		masterU.xfer(8'hA0, 1'b1, q, a);
		masterU.xfer(8'h90, 1'b1, q, a);
		masterU.startCond();
		masterU.xfer(8'hA1, 1'b1, q, a);
		masterU.xfer(8'hFF, 1'b0, q, a);
		cmp(q, 8'h22);
		masterU.xfer(8'hFF, 1'b1, q, a);
		masterU.stopCond();
		cmp(q, 8'h33);
		cmp({6'h0, busy, sdaOut}, 8'h00);
	endtask : scnPage
	task automatic print_verdict();
		if (bad_count == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : print_verdict
	initial begin
		repeat (16) @(posedge clk_sys);
		rstn <= 1'b1;
		repeat (8) @(posedge clk_sys);
		scnPlain();
		scnSelect();
		scnHard();
		scnSoft();
		scnPerm();
		scnPage();
		print_verdict();
	end
	// Hang guard
	initial begin
		repeat (60000) @(posedge clk_sys);
		bad_count++;
		print_verdict();
	end
endmodule : eeprom_write_protect_addressing_tb
`default_nettype wire

/* File: verif/two_wire_master.sv */
// Two-wire bus master model
`timescale 1ns/1ns
`default_nettype none
module two_wire_master (
	input wire logic clk_sys,
	input wire logic sdaWire,
	output var logic sclLine,
	output var logic masterOe
);
	// ****
	// Bus cycles
	// ****
	initial begin
		sclLine = 1'b1;
		masterOe = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : tick
	// Also a repeated start
	task automatic startCond();
		masterOe <= 1'b0;
		tick(5);
		sclLine <= 1'b1;
		tick(10);
		masterOe <= 1'b1;
		tick(10);
		sclLine <= 1'b0;
		tick(5);
	endtask : startCond
	// Sampled late in high, so slow answers count
	task automatic slot(input logic b, output logic r);
		masterOe <= !b;
		tick(5);
		sclLine <= 1'b1;
		tick(9);
		@(negedge clk_sys);
		r = sdaWire;
		@(posedge clk_sys);
		sclLine <= 1'b0;
		tick(5);
	endtask : slot
	task automatic xfer(input logic [7:0] d, input logic m, output logic [7:0] q, output logic ack);
		logic a;
		for (int i = 7; i >= 0; i--) begin
			slot(d[i], q[i]);
		end
		slot(m, a);
		ack = !a;
	endtask : xfer
	task automatic stopCond();
		masterOe <= 1'b1;
		tick(5);
		sclLine <= 1'b1;
		tick(10);
		masterOe <= 1'b0;
		tick(20);
	endtask : stopCond
endmodule : two_wire_master
`default_nettype wire
